// [ocb_pkg.sv]
// package: register map, field layout and types of the overlay back end
package ocb_pkg;
  localparam int unsigned NUM_WIN = 8;
  localparam int unsigned NUM_CH = 3;
  // register byte offsets
  localparam logic [9:0] REG_CTRL = 10'h000;
  localparam logic [9:0] REG_CUR_POS = 10'h004;
  localparam logic [9:0] REG_CUR_SIZE = 10'h008;
  localparam logic [9:0] REG_CUR_COL0 = 10'h00C;
  localparam logic [9:0] REG_CUR_COL1 = 10'h010;
  localparam logic [9:0] REG_CUR_BLINK = 10'h014;
  localparam logic [9:0] REG_WIN_ATTR = 10'h020;
  localparam logic [9:0] REG_BLT_SRC = 10'h040;
  localparam logic [9:0] REG_BLT_DST = 10'h044;
  localparam logic [9:0] REG_BLT_DIM = 10'h048;
  localparam logic [9:0] REG_BLT_PITCH = 10'h04C;
  localparam logic [9:0] REG_BLT_FILL = 10'h050;
  localparam logic [9:0] REG_BLT_CTRL = 10'h054;
  localparam logic [9:0] REG_BLT_STAT = 10'h058;
  localparam logic [9:0] REG_BLT_GOT = 10'h05C;
  localparam logic [9:0] REG_SHAPE = 10'h100;
  localparam int unsigned SHAPE_WORDS = 48;
  // control bits
  localparam int unsigned CT_CUR_EN = 0;
  localparam int unsigned CT_CUR_TWO = 1;
  localparam int unsigned CT_MIRROR = 2;
  localparam int unsigned CT_STRETCH = 3;
  localparam int unsigned CT_TRANSP = 4;
  localparam int unsigned CT_ACT_EN = 5;
  // window attribute fields
  localparam int unsigned WA_EN = 0;
  localparam int unsigned WA_OCS = 1;
  localparam int unsigned WA_BLEND = 4;
  localparam int unsigned WA_FACT = 8;
  // cursor limits
  localparam logic [6:0] CUR_W_TWO = 7'h20;
  localparam logic [6:0] CUR_W_ONE = 7'h40;
  localparam logic [5:0] CUR_H = 6'h18;
  // channel indices
  localparam int unsigned CH_ENC = 0;
  localparam int unsigned CH_DIG = 1;
  localparam int unsigned CH_RGB = 2;
  // transfer control fields
  localparam int unsigned BC_START = 0;
  localparam int unsigned BC_FILL = 1;
  localparam int unsigned BC_TRANSP = 2;
  localparam int unsigned BC_SMEM = 4;
  localparam int unsigned BC_DMEM = 5;
  localparam int unsigned BC_SFMT = 8;
  localparam int unsigned BC_DFMT = 12;
  localparam int unsigned BC_SBPP = 16;
  localparam int unsigned BC_DBPP = 18;
  typedef enum logic [2:0] {FMT_444, FMT_444_HR, FMT_422, FMT_BMP, FMT_BMP_HR} ocb_fmt_t;
  typedef struct packed {logic valid; logic [9:0] x; logic [9:0] y; logic [23:0] ycc;} ocb_pix_t;
  typedef struct packed {logic valid; logic [23:0] ycc;} ocb_chan_t;
  typedef struct packed {logic valid; logic we; logic sel; logic [23:0] addr; logic [31:0] wdata;} ocb_mem_req_t;
endpackage : ocb_pkg

// [ocb_osd_core.sv]
// overlay back end: cursor, window mixing, channel routing, block transfer
//
// Chosen here: the address map and the Avalon-MM slave port.
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// R1: cursor on window zero, up to 32x24 two-colour or 64x24 one-colour.
// R2: an active cursor pixel is drawn above every other window.
// R3: optional vertical mirror and 2x horizontal stretch enlarge the cursor.
// R4: with the cursor enabled, window zero is removed from general overlay use.
// R5: with the cursor disabled, window zero is an ordinary window.
// R6: cursor size, colours, shape and blink period are software settable.
// R7: every enabled window carries a three-bit output channel select.
// R8: select bit per channel picks mixed overlay or pure video.
// R9: overlay-active output is high while overlay pixels reach the RGB path.
// R10: enabling overlay-active makes the composite output invalid.
// R11: only the top window of an overlap reaches any channel.
// R12: transfer reads source, shifts, masks, merges, expands, writes destination.
// R13: set/get pixel, lines, fill, font, bitmap copy and transparent copy.
// R14: source and destination each in SDRAM or extension-bus memory.
// R15: only the listed format pairs are accepted; others flag an error.
// R16: bitmap depth change drops upper bits or fills zeros.
// R17: host programs even widths for half-resolution transfers.
// R18: 4:2:2 data is moved as whole aligned 32-bit words.
// R19: transparent copy skips zero source pixels, writes the rest.
// R20: transparent copy only bitmap to bitmap or bitmap to 4:4:4.
// R21: with transparency and blending, zero overlay pixel shows video only.
// R22: blend factor N weights overlay (N+1)/16, video the rest.
// R23: lower window index has higher priority.
// R24: transfer busy flag is readable by software.
module ocb_osd_core #(
  parameter int unsigned WIN_CNT = 8
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // avalon-mm slave
  input wire logic [9:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // pixel stream from decoder and window fetch
  input wire ocb_pkg::ocb_pix_t i_pix,
  input wire logic i_frame_start,
  input wire logic [WIN_CNT-1:0] i_win_hit,
  input wire logic [WIN_CNT-1:0] i_win_zero,
  input wire logic [WIN_CNT*24-1:0] i_win_ycc,
  // channel outputs
  output ocb_pkg::ocb_chan_t [ocb_pkg::NUM_CH-1:0] o_chan,
  output logic o_overlay_active_out,
  output logic o_cvbs_valid,
  // transfer memory port
  output ocb_pkg::ocb_mem_req_t o_mem_req,
  input wire logic i_mem_ack,
  input wire logic [31:0] i_mem_rdata
);
  import ocb_pkg::*;

  if (WIN_CNT < 2 || WIN_CNT > NUM_WIN) begin : g_chk
    $error("WIN_CNT must be 2..8");
  end

  typedef enum {BL_IDLE, BL_RD_SRC, BL_RD_DST, BL_WR, BL_NEXT} ocb_bl_t;

  // reset release through two flops
  logic rst_a_r, rst_n_s;
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_a_r <= 1'b0;
      rst_n_s <= 1'b0;
    end else begin
      rst_a_r <= 1'b1;
      rst_n_s <= rst_a_r;
    end
  end

  // register state
  logic ack_r, ack_nxt;
  logic [31:0] rd_r, rd_nxt;
  logic [5:0] ctrl_r, ctrl_nxt;
  logic [31:0] pos_r, pos_nxt, size_r, size_nxt, col0_r, col0_nxt, col1_r, col1_nxt;
  logic [15:0] blink_r, blink_nxt;
  logic [11:0] attr_r [WIN_CNT], attr_nxt [WIN_CNT];
  logic [31:0] shape_r [SHAPE_WORDS], shape_nxt [SHAPE_WORDS];
  logic [23:0] bsrc_r, bsrc_nxt, bdst_r, bdst_nxt;
  logic [31:0] bdim_r, bdim_nxt, bpitch_r, bpitch_nxt, bfill_r, bfill_nxt, bctl_r, bctl_nxt;
  logic berr_r, berr_nxt;
  logic busy, go, legal;
  logic [31:0] got_r;
  logic [9:0] wa;
  logic acc;

  function automatic logic [31:0] be_merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] be);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) r[8*b +: 8] = n[8*b +: 8];
    end
    return r;
  endfunction

  // allowed format pairs, with transparency limited to bitmap sources
  function automatic logic fmt_ok(input logic [2:0] s, input logic [2:0] d, input logic tr);
    logic ok;
    ok = 1'b0;
    unique case (s)
      FMT_444, FMT_444_HR: ok = (d == FMT_444 || d == FMT_444_HR) && !tr;
      FMT_422: ok = (d == FMT_422) && !tr;
      FMT_BMP, FMT_BMP_HR: ok = (d != FMT_422) && (d <= FMT_BMP_HR);
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  assign wa = {i_avs_address[9:2], 2'b00};
  assign acc = (i_avs_read || i_avs_write) && ack_r;
  // one wait cycle per access; the answer stands on the second edge
  assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack_r;
  assign o_avs_readdata = rd_r;
  assign legal = fmt_ok(i_avs_writedata[BC_SFMT +: 3], i_avs_writedata[BC_DFMT +: 3],
    i_avs_writedata[BC_TRANSP]); // [R15] [R20]
  assign go = i_avs_write && acc && wa == REG_BLT_CTRL && i_avs_writedata[BC_START] && !busy;

  // bus decode, register writes and read mux
  always_comb begin
    ack_nxt = (i_avs_read || i_avs_write) && !ack_r;
    rd_nxt = rd_r;
    ctrl_nxt = ctrl_r;
    pos_nxt = pos_r;
    size_nxt = size_r;
    col0_nxt = col0_r;
    col1_nxt = col1_r;
    blink_nxt = blink_r;
    attr_nxt = attr_r;
    shape_nxt = shape_r;
    bsrc_nxt = bsrc_r;
    bdst_nxt = bdst_r;
    bdim_nxt = bdim_r;
    bpitch_nxt = bpitch_r;
    bfill_nxt = bfill_r;
    bctl_nxt = bctl_r;
    berr_nxt = berr_r;
    if (i_avs_write && acc) begin
      if (wa == REG_CTRL) ctrl_nxt = 6'(be_merge({26'h0, ctrl_r}, i_avs_writedata, i_avs_byteenable));
      if (wa == REG_CUR_POS) pos_nxt = be_merge(pos_r, i_avs_writedata, i_avs_byteenable); // [R6]
      if (wa == REG_CUR_SIZE) size_nxt = be_merge(size_r, i_avs_writedata, i_avs_byteenable); // [R6]
      if (wa == REG_CUR_COL0) col0_nxt = be_merge(col0_r, i_avs_writedata, i_avs_byteenable); // [R6]
      if (wa == REG_CUR_COL1) col1_nxt = be_merge(col1_r, i_avs_writedata, i_avs_byteenable); // [R6]
      if (wa == REG_CUR_BLINK) blink_nxt = 16'(be_merge({16'h0, blink_r}, i_avs_writedata, i_avs_byteenable));
      for (int w = 0; w < WIN_CNT; w++) begin
        if (wa == REG_WIN_ATTR + 10'(4 * w))
          attr_nxt[w] = 12'(be_merge({20'h0, attr_r[w]}, i_avs_writedata, i_avs_byteenable)); // [R7]
      end
      for (int s = 0; s < SHAPE_WORDS; s++) begin
        if (wa == REG_SHAPE + 10'(4 * s))
          shape_nxt[s] = be_merge(shape_r[s], i_avs_writedata, i_avs_byteenable); // [R6]
      end
      // transfer setup is frozen while a transfer runs
      if (!busy) begin
        if (wa == REG_BLT_SRC) bsrc_nxt = 24'(be_merge({8'h0, bsrc_r}, i_avs_writedata, i_avs_byteenable));
        if (wa == REG_BLT_DST) bdst_nxt = 24'(be_merge({8'h0, bdst_r}, i_avs_writedata, i_avs_byteenable));
        if (wa == REG_BLT_DIM) bdim_nxt = be_merge(bdim_r, i_avs_writedata, i_avs_byteenable);
        if (wa == REG_BLT_PITCH) bpitch_nxt = be_merge(bpitch_r, i_avs_writedata, i_avs_byteenable);
        if (wa == REG_BLT_FILL) bfill_nxt = be_merge(bfill_r, i_avs_writedata, i_avs_byteenable);
        if (wa == REG_BLT_CTRL) begin
          bctl_nxt = i_avs_writedata;
          if (i_avs_writedata[BC_START]) berr_nxt = !legal; // [R15]
        end
      end
    end
    if ((i_avs_read || i_avs_write) && !ack_r) begin
      rd_nxt = 32'h0;
      if (wa == REG_CTRL) rd_nxt = {26'h0, ctrl_r};
      if (wa == REG_CUR_POS) rd_nxt = pos_r;
      if (wa == REG_CUR_SIZE) rd_nxt = size_r;
      if (wa == REG_CUR_COL0) rd_nxt = col0_r;
      if (wa == REG_CUR_COL1) rd_nxt = col1_r;
      if (wa == REG_CUR_BLINK) rd_nxt = {16'h0, blink_r};
      for (int w = 0; w < WIN_CNT; w++) begin
        if (wa == REG_WIN_ATTR + 10'(4 * w)) rd_nxt = {20'h0, attr_r[w]};
      end
      for (int s = 0; s < SHAPE_WORDS; s++) begin
        if (wa == REG_SHAPE + 10'(4 * s)) rd_nxt = shape_r[s];
      end
      if (wa == REG_BLT_SRC) rd_nxt = {8'h0, bsrc_r};
      if (wa == REG_BLT_DST) rd_nxt = {8'h0, bdst_r};
      if (wa == REG_BLT_DIM) rd_nxt = bdim_r;
      if (wa == REG_BLT_PITCH) rd_nxt = bpitch_r;
      if (wa == REG_BLT_FILL) rd_nxt = bfill_r;
      if (wa == REG_BLT_CTRL) rd_nxt = bctl_r;
      if (wa == REG_BLT_STAT) rd_nxt = {30'h0, berr_r, busy}; // [R24]
      if (wa == REG_BLT_GOT) rd_nxt = got_r; // [R13]
    end
  end

  always_ff @(posedge i_clk_sys or negedge rst_n_s) begin
    if (!rst_n_s) begin
      ack_r <= 1'b0;
      rd_r <= 32'h0;
      ctrl_r <= 6'h0;
      pos_r <= 32'h0;
      size_r <= 32'h0;
      col0_r <= 32'h0;
      col1_r <= 32'h0;
      blink_r <= 16'h0;
      attr_r <= '{default: 12'h0};
      shape_r <= '{default: 32'h0};
      bsrc_r <= 24'h0;
      bdst_r <= 24'h0;
      bdim_r <= 32'h0;
      bpitch_r <= 32'h0;
      bfill_r <= 32'h0;
      bctl_r <= 32'h0;
      berr_r <= 1'b0;
    end else begin
      ack_r <= ack_nxt;
      rd_r <= rd_nxt;
      ctrl_r <= ctrl_nxt;
      pos_r <= pos_nxt;
      size_r <= size_nxt;
      col0_r <= col0_nxt;
      col1_r <= col1_nxt;
      blink_r <= blink_nxt;
      attr_r <= attr_nxt;
      shape_r <= shape_nxt;
      bsrc_r <= bsrc_nxt;
      bdst_r <= bdst_nxt;
      bdim_r <= bdim_nxt;
      bpitch_r <= bpitch_nxt;
      bfill_r <= bfill_nxt;
      bctl_r <= bctl_nxt;
      berr_r <= berr_nxt;
    end
  end

  // blink: visibility toggles every blink_r frames, zero means steady
  logic [15:0] bcnt_r, bcnt_nxt;
  logic vis_r, vis_nxt;
  always_comb begin
    bcnt_nxt = bcnt_r;
    vis_nxt = vis_r;
    if (blink_r == 16'h0) begin
      vis_nxt = 1'b1;
      bcnt_nxt = 16'h0;
    end else if (i_frame_start) begin
      bcnt_nxt = bcnt_r + 16'h1;
      if (bcnt_nxt >= blink_r) begin
        bcnt_nxt = 16'h0;
        vis_nxt = !vis_r; // [R6]
      end
    end
  end
  always_ff @(posedge i_clk_sys or negedge rst_n_s) begin
    if (!rst_n_s) begin
      bcnt_r <= 16'h0;
      vis_r <= 1'b1;
    end else begin
      bcnt_r <= bcnt_nxt;
      vis_r <= vis_nxt;
    end
  end

  // cursor geometry and shape lookup
  logic cur_en, cur_on, cur_two;
  logic [6:0] cw;
  logic [5:0] ch;
  logic [10:0] dx, dy, colx, rowy;
  logic [63:0] srow;
  logic [1:0] code;
  assign cur_en = ctrl_r[CT_CUR_EN];
  assign cur_two = ctrl_r[CT_CUR_TWO];
  always_comb begin
    cw = cur_two ? CUR_W_TWO : CUR_W_ONE; // [R1]
    if (size_r[6:0] < cw) cw = size_r[6:0];
    ch = (size_r[13:8] < CUR_H) ? size_r[13:8] : CUR_H; // [R1]
    dx = {1'b0, i_pix.x} - {1'b0, pos_r[9:0]};
    dy = {1'b0, i_pix.y} - {1'b0, pos_r[25:16]};
    colx = ctrl_r[CT_STRETCH] ? {1'b0, dx[10:1]} : dx; // [R3]
    rowy = dy;
    if (ctrl_r[CT_MIRROR] && dy >= 11'(ch)) rowy = 11'({ch, 1'b0}) - 11'h1 - dy; // [R3]
    srow = 64'h0;
    code = 2'b00;
    if (!dx[10] && !dy[10] && colx < 11'(cw) && rowy < 11'(ch)) begin
      srow = {shape_r[2 * rowy[4:0]], shape_r[2 * rowy[4:0] + 1]};
      code = cur_two ? srow[6'(63 - 2 * colx[4:0]) -: 2] : {1'b0, srow[6'(63 - colx[5:0])]};
    end
    cur_on = cur_en && vis_r && code != 2'b00;
  end

  // window priority: lowest index wins, window zero yields to the cursor
  logic [2:0] sel;
  logic sel_v;
  logic [11:0] at;
  logic [23:0] ov;
  logic ovis;
  logic [23:0] mix;
  always_comb begin
    sel = 3'h0;
    sel_v = 1'b0;
    for (int w = WIN_CNT - 1; w >= 0; w--) begin
      if (i_win_hit[w] && attr_r[w][WA_EN] && !(w == 0 && cur_en)) begin // [R4] [R5]
        sel = 3'(w); // [R23] [R11]
        sel_v = 1'b1;
      end
    end
    at = attr_r[sel];
    ov = i_win_ycc[24 * sel +: 24];
    ovis = sel_v && !(ctrl_r[CT_TRANSP] && i_win_zero[sel]); // [R21]
    mix = ov;
    if (at[WA_BLEND]) begin
      for (int c = 0; c < 3; c++) begin
        mix[8 * c +: 8] = 8'(({5'h0, ov[8 * c +: 8]} * ({9'h0, at[WA_FACT +: 4]} + 13'h1) +
          {5'h0, i_pix.ycc[8 * c +: 8]} * (13'hF - {9'h0, at[WA_FACT +: 4]})) >> 4); // [R22]
      end
    end
    if (cur_on) begin
      at = attr_r[0];
      mix = code[1] ? col1_r[23:0] : col0_r[23:0]; // [R2]
      ovis = 1'b1;
    end
  end

  // per-channel routing, registered
  ocb_chan_t [NUM_CH-1:0] chan_r, chan_nxt;
  logic act_r, act_nxt;
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    assign chan_nxt[c].valid = i_pix.valid;
    assign chan_nxt[c].ycc = (ovis && at[WA_OCS + c]) ? mix : i_pix.ycc; // [R8] [R7]
  end
  assign act_nxt = ctrl_r[CT_ACT_EN] && i_pix.valid && ovis && at[WA_OCS + CH_RGB]; // [R9]
  always_ff @(posedge i_clk_sys or negedge rst_n_s) begin
    if (!rst_n_s) begin
      chan_r <= '0;
      act_r <= 1'b0;
    end else begin
      chan_r <= chan_nxt;
      act_r <= act_nxt;
    end
  end
  assign o_chan = chan_r;
  assign o_overlay_active_out = act_r;
  assign o_cvbs_valid = !ctrl_r[CT_ACT_EN]; // [R10]

  // block transfer engine: one pixel per read-modify-write
  ocb_bl_t st_r, st_nxt;
  logic [9:0] cx_r, cx_nxt, cy_r, cy_nxt;
  logic [31:0] spx_r, spx_nxt, dw_r, dw_nxt, got_nxt;
  logic [5:0] sbits, dbits;
  logic [31:0] sbit, dbit, smask;
  logic [4:0] ssh, dsh;
  logic skip;
  function automatic logic [5:0] unit_bits(input logic [2:0] f, input logic [1:0] lg);
    // 4:2:2 moves two pixels per aligned word, 4:4:4 one pixel per word
    return (f == FMT_BMP || f == FMT_BMP_HR) ? 6'(1 << lg) : 6'h20; // [R18]
  endfunction
  assign busy = st_r != BL_IDLE;
  always_comb begin
    sbits = unit_bits(bctl_r[BC_SFMT +: 3], bctl_r[BC_SBPP +: 2]);
    dbits = unit_bits(bctl_r[BC_DFMT +: 3], bctl_r[BC_DBPP +: 2]);
    sbit = (32'(cy_r) * 32'(bpitch_r[15:0]) + 32'(cx_r)) * 32'(sbits);
    dbit = (32'(cy_r) * 32'(bpitch_r[31:16]) + 32'(cx_r)) * 32'(dbits);
    ssh = 5'(6'h20 - sbits - {1'b0, sbit[4:0]});
    dsh = 5'(6'h20 - dbits - {1'b0, dbit[4:0]});
    smask = 32'((33'h1 << dbits) - 33'h1); // [R16]
    skip = bctl_r[BC_TRANSP] && spx_r == 32'h0; // [R19]
    st_nxt = st_r;
    cx_nxt = cx_r;
    cy_nxt = cy_r;
    spx_nxt = spx_r;
    dw_nxt = dw_r;
    got_nxt = got_r;
    o_mem_req = '0;
    unique case (st_r)
      BL_IDLE: begin
        if (go && legal) begin
          cx_nxt = 10'h0;
          cy_nxt = 10'h0;
          st_nxt = i_avs_writedata[BC_FILL] ? BL_RD_DST : BL_RD_SRC; // [R13]
          spx_nxt = bfill_r;
        end
      end
      BL_RD_SRC: begin
        o_mem_req = '{1'b1, 1'b0, bctl_r[BC_SMEM], bsrc_r + 24'(sbit >> 5), 32'h0}; // [R14]
        if (i_mem_ack) begin
          spx_nxt = (i_mem_rdata >> ssh) & 32'((33'h1 << sbits) - 33'h1); // [R12]
          got_nxt = spx_nxt;
          st_nxt = BL_RD_DST;
        end
      end
      BL_RD_DST: begin
        o_mem_req = '{1'b1, 1'b0, bctl_r[BC_DMEM], bdst_r + 24'(dbit >> 5), 32'h0}; // [R14]
        if (i_mem_ack) begin
          dw_nxt = (i_mem_rdata & ~(smask << dsh)) | ((spx_r & smask) << dsh); // [R12] [R16]
          st_nxt = skip ? BL_NEXT : BL_WR; // [R19]
        end
      end
      BL_WR: begin
        o_mem_req = '{1'b1, 1'b1, bctl_r[BC_DMEM], bdst_r + 24'(dbit >> 5), dw_r};
        if (i_mem_ack) st_nxt = BL_NEXT;
      end
      BL_NEXT: begin
        st_nxt = bctl_r[BC_FILL] ? BL_RD_DST : BL_RD_SRC;
        cx_nxt = cx_r + 10'h1;
        if (cx_nxt >= bdim_r[9:0]) begin
          cx_nxt = 10'h0;
          cy_nxt = cy_r + 10'h1;
          if (cy_nxt >= bdim_r[25:16]) st_nxt = BL_IDLE;
        end
      end
    endcase
  end
  always_ff @(posedge i_clk_sys or negedge rst_n_s) begin
    if (!rst_n_s) begin
      st_r <= BL_IDLE;
      cx_r <= 10'h0;
      cy_r <= 10'h0;
      spx_r <= 32'h0;
      dw_r <= 32'h0;
      got_r <= 32'h0;
    end else begin
      st_r <= st_nxt;
      cx_r <= cx_nxt;
      cy_r <= cy_nxt;
      spx_r <= spx_nxt;
      dw_r <= dw_nxt;
      got_r <= got_nxt;
    end
  end

  // checks
  property p_busy;
    @(posedge i_clk_sys) disable iff (!rst_n_s) go && legal |=> busy && !berr_r;
  endproperty
  a_busy: assert property (p_busy) else $error("transfer did not go busy"); // [R24]
  property p_illegal;
    @(posedge i_clk_sys) disable iff (!rst_n_s) go && !legal |=> !busy && berr_r;
  endproperty
  a_illegal: assert property (p_illegal) else $error("illegal transfer started"); // [R15]
  property p_skip;
    @(posedge i_clk_sys) disable iff (!rst_n_s) st_r == BL_RD_DST && i_mem_ack && skip |=> st_r == BL_NEXT;
  endproperty
  a_skip: assert property (p_skip) else $error("zero pixel written"); // [R19]
  property p_video;
    @(posedge i_clk_sys) disable iff (!rst_n_s) i_pix.valid && !ovis |=> o_chan[CH_ENC].ycc == $past(i_pix.ycc);
  endproperty
  a_video: assert property (p_video) else $error("video not passed"); // [R8]
  property p_cursor;
    @(posedge i_clk_sys) disable iff (!rst_n_s)
      cur_on && attr_r[0][WA_OCS + CH_RGB] |=> o_chan[CH_RGB].ycc == $past(mix) && o_chan[CH_RGB].ycc != 24'h0 ||
      $past(mix) == 24'h0;
  endproperty
  a_cursor: assert property (p_cursor) else $error("cursor not on top"); // [R2]
  property p_act;
    @(posedge i_clk_sys) disable iff (!rst_n_s) o_overlay_active_out |-> !o_cvbs_valid;
  endproperty
  a_act: assert property (p_act) else $error("composite valid with overlay active"); // [R10]
  property p_win0;
    @(posedge i_clk_sys) disable iff (!rst_n_s) cur_en && sel_v |-> sel != 3'h0;
  endproperty
  a_win0: assert property (p_win0) else $error("window zero used with cursor"); // [R4]
  property p_prio;
    @(posedge i_clk_sys) disable iff (!rst_n_s) i_win_hit[0] && attr_r[0][WA_EN] && !cur_en |-> sel == 3'h0;
  endproperty
  a_prio: assert property (p_prio) else $error("priority wrong"); // [R23]
endmodule : ocb_osd_core
`default_nettype wire

// [ocb_mem_model.sv]
// memory partner: two word banks answering the transfer port
`timescale 1ns/10ps
`default_nettype none
module ocb_mem_model (
  // clock
  input wire logic i_clk_sys,
  // request in, answer out
  input wire ocb_pkg::ocb_mem_req_t i_req,
  output logic o_ack,
  output logic [31:0] o_rdata
);
  import ocb_pkg::*;
  logic [31:0] mem [2][256];
  int seed = 66;
  int wait_n = 0;
  initial begin
    o_ack = 1'b0;
    o_rdata = 32'h0;
  end
  // slow or prompt answers; data toggles outside the ack so stale data is never trusted
  always @(posedge i_clk_sys) begin
    o_ack <= 1'b0;
    o_rdata <= ~o_rdata;
    if (i_req.valid && !o_ack) begin
      if (wait_n > 0) begin
        wait_n <= wait_n - 1;
      end else begin
        o_ack <= 1'b1;
        wait_n <= $random(seed) & 3;
        if (i_req.we) mem[i_req.sel][i_req.addr[7:0]] <= i_req.wdata;
        else o_rdata <= mem[i_req.sel][i_req.addr[7:0]];
      end
    end
  end
endmodule : ocb_mem_model
`default_nettype wire

// [ocb_osd_core_test.sv]
// self-checking bench: register bus, channel routing, cursor, transfer engine
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin error_cnt++; \
  $display("unexpected at %0t: got %h want %h", $time, a, e); end end
module ocb_osd_core_test;
  import ocb_pkg::*;
  logic clk = 0, rst_n = 0, rd = 0, wr = 0, fs = 0, wq, ack, act, cvbs;
  logic [9:0] adr = 10'h000;
  logic [31:0] wd = 32'h0, rdat, q, rdata;
  logic [3:0] be = 4'hF;
  logic [7:0] hit = 8'h00, zro = 8'h00;
  logic [191:0] wycc;
  logic [23:0] vid;
  ocb_pix_t pix = '0;
  ocb_chan_t [2:0] ch;
  ocb_mem_req_t req;
  int error_cnt = 0, comparisons = 0, seed = 66;
  initial forever #10 clk = ~clk;
  ocb_osd_core #(.WIN_CNT(8)) uut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(be), .o_avs_readdata(rdat),
    .o_avs_waitrequest(wq), .i_pix(pix), .i_frame_start(fs), .i_win_hit(hit), .i_win_zero(zro),
    .i_win_ycc(wycc), .o_chan(ch), .o_overlay_active_out(act), .o_cvbs_valid(cvbs), .o_mem_req(req),
    .i_mem_ack(ack), .i_mem_rdata(rdata));
  ocb_mem_model mdl (.i_clk_sys(clk), .i_req(req), .o_ack(ack), .o_rdata(rdata));
  task results;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results
  // one avalon access, held until waitrequest is sampled low
  task bus(input logic w, input logic [9:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    adr <= a; wd <= d; rd <= !w; wr <= w;
    n = 0;
    // look at waitrequest mid-cycle, where it has settled, then let the taking edge pass
    do begin @(negedge clk); n++; end while (wq !== 1'b0 && n < 20);
    if (n >= 20) begin error_cnt++; results(); end
    q = rdat;
    @(posedge clk);
    rd <= 1'b0; wr <= 1'b0;
  endtask : bus
  // one pixel; mask m says which channels carry overlay colour oc
  task px(input logic [7:0] h, z, input logic [9:0] x, y, input logic [2:0] m, input logic [23:0] oc);
    @(posedge clk);
    vid = 24'($random(seed));
    pix <= '{1'b1, x, y, vid}; hit <= h; zro <= z;
    @(posedge clk); @(negedge clk);
    for (int c = 0; c < 3; c++) `CHK(ch[c], {1'b1, m[c] ? oc : vid})
    `CHK(act, m[2])
  endtask : px
  // program and run one transfer, bounded poll of busy
  task blt(input logic [31:0] s, d, dim, ctl);
    int n;
    bus(1, REG_BLT_SRC, s); bus(1, REG_BLT_DST, d); bus(1, REG_BLT_DIM, dim);
    bus(1, REG_BLT_PITCH, 32'h00040004); bus(1, REG_BLT_CTRL, ctl);
    n = 0;
    do begin bus(0, REG_BLT_STAT, 0); n++; end while (q[0] !== 1'b0 && n < 200);
    if (n >= 200) begin error_cnt++; results(); end
  endtask : blt
  function automatic logic [23:0] wc(int w);
    return wycc[24*w+:24];
  endfunction : wc
  initial begin
    for (int w = 0; w < 8; w++) wycc[24*w+:24] = 24'h202020 + 24'h010101 * w;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK(cvbs, 1'b1)
    bus(0, 10'h3FC, 0); `CHK(q, 32'h0)
    bus(1, REG_CTRL, 32'h20); bus(0, REG_CTRL, 0); `CHK(q, 32'h20)
    for (int s = 0; s < 8; s++) begin
      bus(1, REG_WIN_ATTR + 4, 1 | (s << 1));
      px(8'h02, 8'h00, 0, 0, 3'(s), wc(1));
    end
    `CHK(cvbs, 1'b0)
    bus(1, REG_WIN_ATTR, 32'hF); bus(1, REG_WIN_ATTR + 8, 32'hF);
    px(8'h06, 8'h00, 0, 0, 3'h7, wc(1));
    px(8'h03, 8'h00, 0, 0, 3'h7, wc(0));
    bus(1, REG_CTRL, 32'h30); bus(1, REG_WIN_ATTR + 4, 32'hF1F);
    px(8'h02, 8'h02, 0, 0, 3'h0, 0);
    px(8'h02, 8'h00, 0, 0, 3'h7, wc(1));
    bus(1, REG_SHAPE, 32'hFFFFFFFF); bus(1, REG_SHAPE + 4, 32'hFFFFFFFF);
    bus(1, REG_CUR_POS, 32'h00640064); bus(1, REG_CUR_SIZE, 32'h1820);
    bus(1, REG_CUR_COL1, 32'hE0D0); bus(1, REG_CUR_BLINK, 0);
    bus(1, REG_WIN_ATTR + 4, 32'hF); bus(1, REG_CTRL, 32'h23);
    px(8'h03, 8'h00, 0, 0, 3'h7, wc(1));
    px(8'h03, 8'h00, 100, 100, 3'h7, 24'hE0D0);
    px(8'h03, 8'h00, 140, 100, 3'h7, wc(1));
    bus(1, REG_CTRL, 32'h2B);
    px(8'h03, 8'h00, 140, 100, 3'h7, 24'hE0D0);
    // copies across all four memory pairings
    for (int k = 0; k < 4; k++) begin
      mdl.mem[k & 1][16] = $random(seed);
      mdl.mem[k & 1][17] = $random(seed);
      blt(16, 32 + 4 * k, 32'h00010002, 1 | ((k & 1) << 4) | ((k >> 1) << 5));
      for (int i = 0; i < 2; i++) `CHK(mdl.mem[k >> 1][32 + 4 * k + i], mdl.mem[k & 1][16 + i])
    end
    mdl.mem[1][48] = 32'h00A500C3; mdl.mem[0][64] = 32'h11223344;
    blt(48, 64, 32'h00010004, 32'h000F3315);
    `CHK(mdl.mem[0][64], 32'h11A533C3)
    mdl.mem[1][80] = 32'h12345678; mdl.mem[0][96] = 32'h0;
    blt(80, 96, 32'h00010004, 32'h000B3311);
    `CHK(mdl.mem[0][96], 32'h24680000)
    bus(1, REG_BLT_FILL, 32'hABCDEF00);
    blt(0, 112, 32'h00010002, 32'h3);
    `CHK(mdl.mem[0][113], 32'hABCDEF00)
    blt(16, 136, 32'h00010002, 32'h2201);
    `CHK(mdl.mem[0][136], mdl.mem[0][16])
    blt(16, 144, 32'h00010002, 32'h1101);
    `CHK(mdl.mem[0][145], mdl.mem[0][17])
    mdl.mem[0][128] = 32'h5A5A5A5A;
    blt(16, 128, 32'h00010002, 32'h0201);
    `CHK(q[1], 1'b1)
    `CHK(mdl.mem[0][128], 32'h5A5A5A5A)
    results();
  end
endmodule : ocb_osd_core_test
`default_nettype wire
